/* rtl/its_pkg.sv */
// constants, register map and types for the i2c target register logic
package its_pkg;
  // register byte offsets on the ahb-lite slave
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_OWN_ID = 8'h0C;
  localparam logic [7:0] OFS_BUFFER = 8'h10;
  localparam logic [7:0] OFS_GO = 8'h14;
  localparam int ADDR_W = 8;
  // control bits
  localparam int CTL_ENABLE = 0;
  localparam int CTL_NACK = 2;
  localparam int CTL_TRANSMIT = 3;
  localparam int CTL_ANY_ADDR = 4;
  // status bits
  localparam int ST_BYTE_DONE = 0;
  localparam int ST_LAST_ACK = 1;
  localparam int ST_ADDR = 3;
  localparam int ST_STOP = 4;
  localparam logic [7:0] STICKY_MASK = 8'h11;
  localparam logic [7:0] STATUS_USED = 8'h1B;
  // reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [6:0] OWN_ID_RST = 7'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // ahb codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int BYTE_BITS = 8;
  localparam int BIT_CNT_W = 4;
  // bit-level engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_ACK_DRIVE,
    ST_ACK_SAMPLE,
    ST_IGNORE
  } its_state_t;
endpackage

/* rtl/its_target.sv */
// i2c target with ahb-lite register file, byte engine and interrupt
//
// Summary of operation
// - control bit 4 accepts every received address
// - control bit 3 selects send or receive after a received data byte; after the address the r/w bit decides
// - control bit 2 answers byte with nack
// - control bit 0 enables; disabled means bus-silent
// - status sampled on system clock edge
// - stop and byte-done sticky, cleared by read
// - address and ack bits live, read-independent
// - status bit 4 set on stop
// - status bit 3 marks address byte
// - status bit 1 holds master's ack bit
// - status bit 0 set per eight-bit byte
// - mask bit enables same-position status bit
// - own-address register holds compared 7-bit address
// - go write releases scl stretch; in send mode it starts byte send
// - outgoing alias shares data register address
//
// The placing of the registers and the AHB-Lite register port were decided locally.
module its_target
  import its_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic NRST_IN,
  // ahb-lite slave
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // i2c pins, split into input, output and enable
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE_OUT,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  // interrupt
  output logic IRQ_OUT
);

  // ---------------- ahb-lite slave ----------------
  logic wr_pend_ff;
  logic [ADDR_W-1:0] wr_addr_ff;
  logic [31:0] rdata_ff;
  // only whole-word transfers are decoded; other sizes are ignored, and a read of them keeps the last read data
  wire addr_phase = HSEL_IN && HREADY_IN && (HSIZE_IN == HSIZE_WORD) &&
                    (HTRANS_IN == HTRANS_NONSEQ || HTRANS_IN == HTRANS_SEQ);
  wire ap_write = addr_phase && HWRITE_IN;
  wire ap_read = addr_phase && !HWRITE_IN;
  wire [ADDR_W-1:0] ap_addr = HADDR_IN[ADDR_W-1:0];
  wire wr_ctl = wr_pend_ff && (wr_addr_ff == OFS_CONTROL);
  wire wr_mask = wr_pend_ff && (wr_addr_ff == OFS_MASK);
  wire wr_own = wr_pend_ff && (wr_addr_ff == OFS_OWN_ID);
  wire wr_buf = wr_pend_ff && (wr_addr_ff == OFS_BUFFER); // alias shares this slot
  wire wr_go = wr_pend_ff && (wr_addr_ff == OFS_GO); // data value ignored
  wire rd_status = ap_read && (ap_addr == OFS_STATUS);

  // writes complete with zero wait states; reads are registered at address phase
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;
  assign HRDATA_OUT = rdata_ff;

  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
    end else begin
      wr_pend_ff <= ap_write;
      wr_addr_ff <= ap_addr;
    end
  end

  // ---------------- registers ----------------
  logic [7:0] control_ff;
  logic [7:0] mask_ff;
  logic [6:0] own_id_ff;
  logic [7:0] byte_ff;
  logic [7:0] sticky_ff;

  // the bit counter must reach a full byte plus the ack phase marker
  if (BIT_CNT_W < $clog2(BYTE_BITS + 1)) begin : g_cnt_check
    $error("bit counter too narrow for one byte");
  end

  // ---------------- pin synchronisers ----------------
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic scl_prev_ff;
  logic sda_prev_ff;
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], SCL_IN};
      sda_sync_ff <= {sda_sync_ff[0], SDA_IN};
      scl_prev_ff <= scl_sync_ff[1];
      sda_prev_ff <= sda_sync_ff[1];
    end
  end
  wire scl_s = scl_sync_ff[1];
  wire sda_s = sda_sync_ff[1];
  wire scl_rise = scl_s && !scl_prev_ff;
  wire scl_fall = !scl_s && scl_prev_ff;
  wire start_seen = scl_s && scl_prev_ff && !sda_s && sda_prev_ff;
  wire stop_seen = scl_s && scl_prev_ff && sda_s && !sda_prev_ff;
  wire enabled = control_ff[CTL_ENABLE];

  // ---------------- byte engine ----------------
  its_state_t state_ff;
  its_state_t nxt_state;
  logic [BIT_CNT_W-1:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic is_addr_ff;
  logic tx_ff;
  logic sda_drv_ff;
  logic last_ack_ff;
  logic addr_flag_ff;
  logic byte_done_pulse;

  wire last_bit = (bit_cnt_ff == BIT_CNT_W'(BYTE_BITS - 1));
  wire [7:0] rx_byte = {shift_ff[6:0], sda_s};
  wire addr_match = (rx_byte[7:1] == own_id_ff);
  wire addr_ok = control_ff[CTL_ANY_ADDR] || addr_match;
  wire want_nack = control_ff[CTL_NACK];
  // direction of the coming byte: r/w bit after an address, else the control bit
  wire next_tx = is_addr_ff ? shift_ff[0] : control_ff[CTL_TRANSMIT];
  // the ninth clock is split in two by the counter: first fall opens, second closes
  wire ack_second = scl_fall && (bit_cnt_ff != '0);

  always_comb begin
    nxt_state = state_ff;
    byte_done_pulse = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        nxt_state = ST_IDLE;
      end
      ST_SHIFT: begin
        if (scl_rise && last_bit) begin
          byte_done_pulse = 1'b1;
          if (tx_ff) begin
            nxt_state = ST_ACK_SAMPLE;
          end else if (is_addr_ff && !addr_ok) begin
            nxt_state = ST_IGNORE;
          end else begin
            nxt_state = ST_ACK_DRIVE;
          end
        end
      end
      ST_ACK_DRIVE: begin
        if (ack_second) begin
          nxt_state = want_nack ? ST_IGNORE : ST_SHIFT;
        end
      end
      ST_ACK_SAMPLE: begin
        if (ack_second) begin
          nxt_state = last_ack_ff ? ST_IGNORE : ST_SHIFT;
        end
      end
      ST_IGNORE: begin
        nxt_state = ST_IGNORE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (start_seen) begin
      nxt_state = ST_SHIFT;
    end
    if (stop_seen || !enabled) begin
      nxt_state = ST_IDLE;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // bit counter, shifter, direction and sda drive
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      bit_cnt_ff <= '0;
      shift_ff <= BYTE_RST;
      is_addr_ff <= 1'b0;
      tx_ff <= 1'b0;
      sda_drv_ff <= 1'b0;
      last_ack_ff <= 1'b0;
      addr_flag_ff <= 1'b0;
    end else if (start_seen || nxt_state == ST_IDLE) begin
      bit_cnt_ff <= '0;
      is_addr_ff <= 1'b1;
      tx_ff <= 1'b0;
      sda_drv_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_SHIFT: begin
          if (scl_rise) begin
            shift_ff <= rx_byte;
            bit_cnt_ff <= last_bit ? '0 : bit_cnt_ff + 1'b1;
            if (last_bit) begin
              addr_flag_ff <= is_addr_ff;
            end
          end
          // the counter already names the next bit when scl falls
          if (scl_fall) begin
            sda_drv_ff <= tx_ff && !byte_ff[3'(BYTE_BITS - 1) - 3'(bit_cnt_ff)];
          end
          // first bit was set up from the old buffer; go reloads it while scl is held
          if (wr_go && tx_ff && (bit_cnt_ff == '0)) begin
            sda_drv_ff <= !byte_ff[BYTE_BITS-1];
          end
        end
        ST_ACK_DRIVE: begin
          if (ack_second) begin
            bit_cnt_ff <= '0;
            sda_drv_ff <= next_tx && !byte_ff[BYTE_BITS-1];
            is_addr_ff <= 1'b0;
            tx_ff <= next_tx;
          end else if (scl_fall) begin
            bit_cnt_ff <= BIT_CNT_W'(1);
            sda_drv_ff <= !want_nack; // ack pulls low, nack leaves sda released
          end
        end
        ST_ACK_SAMPLE: begin
          if (scl_rise) begin
            last_ack_ff <= sda_s;
          end
          if (ack_second) begin
            bit_cnt_ff <= '0;
            sda_drv_ff <= !last_ack_ff && !byte_ff[BYTE_BITS-1];
          end else if (scl_fall) begin
            bit_cnt_ff <= BIT_CNT_W'(1);
            sda_drv_ff <= 1'b0; // master owns sda for its ack
          end
        end
        default: begin
          sda_drv_ff <= 1'b0;
        end
      endcase
    end
  end

  wire rx_load = (state_ff == ST_SHIFT) && scl_rise && last_bit && !tx_ff;

  // stretching starts only after the ack clock: holding scl during the ninth
  // clock would keep the master from ever seeing the answer to its byte
  wire ack_done = ack_second && (nxt_state == ST_SHIFT) &&
                  (state_ff == ST_ACK_DRIVE || state_ff == ST_ACK_SAMPLE);

  // the master is held by scl stretch only until software has acted after a byte
  logic stretch_ff;
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      stretch_ff <= 1'b0;
    end else if (!enabled || stop_seen) begin
      stretch_ff <= 1'b0;
    end else if (ack_done) begin
      stretch_ff <= 1'b1;
    end else if (wr_go || wr_ctl) begin
      stretch_ff <= 1'b0;
    end
  end

  // pins: open drain, only pull low
  assign SDA_OUT = 1'b0;
  assign SDA_OE_OUT = enabled && sda_drv_ff && (state_ff != ST_IDLE) && (state_ff != ST_IGNORE);
  assign SCL_OUT = 1'b0;
  assign SCL_OE_OUT = enabled && stretch_ff && !scl_s;

  // ---------------- register writes ----------------
  wire stop_evt = stop_seen && enabled;
  wire [7:0] sticky_set = ({7'h00, byte_done_pulse} << ST_BYTE_DONE) |
                          ({7'h00, stop_evt} << ST_STOP);
  // a read clears sticky bits, but a same-cycle event still wins
  wire [7:0] sticky_clr = rd_status ? STICKY_MASK : 8'h00;
  wire [7:0] live_bits = ({7'h00, last_ack_ff} << ST_LAST_ACK) |
                         ({7'h00, addr_flag_ff} << ST_ADDR);
  wire [7:0] status_view = ((sticky_ff & STICKY_MASK) | live_bits) & STATUS_USED;

  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      control_ff <= CONTROL_RST;
      mask_ff <= MASK_RST;
      own_id_ff <= OWN_ID_RST;
      byte_ff <= BYTE_RST;
      sticky_ff <= 8'h00;
    end else begin
      if (wr_ctl) begin
        control_ff <= HWDATA_IN[7:0];
      end
      if (wr_mask) begin
        mask_ff <= HWDATA_IN[7:0];
      end
      if (wr_own) begin
        own_id_ff <= HWDATA_IN[6:0];
      end
      if (rx_load) begin
        byte_ff <= rx_byte;
      end else if (wr_buf) begin
        byte_ff <= HWDATA_IN[7:0];
      end
      sticky_ff <= (sticky_ff & ~sticky_clr) | sticky_set;
    end
  end

  // ---------------- read data ----------------
  wire [7:0] rd_mux = (ap_addr == OFS_CONTROL) ? control_ff :
                      (ap_addr == OFS_STATUS) ? status_view :
                      (ap_addr == OFS_MASK) ? mask_ff :
                      (ap_addr == OFS_OWN_ID) ? {1'b0, own_id_ff} :
                      (ap_addr == OFS_BUFFER) ? byte_ff : 8'h00;
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      rdata_ff <= 32'h0000_0000;
    end else if (ap_read) begin
      rdata_ff <= {24'h00_0000, rd_mux};
    end
  end

  // ---------------- interrupt ----------------
  assign IRQ_OUT = |(status_view & mask_ff);

endmodule

/* verification/its_master_model.sv */
// i2c master model: open-drain pulls, 64 ns bit time, waits out stretching
module its_master_model (
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_low_out,
  output logic sda_low_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    sda_low_out = !b;
    #16 scl_low_out = 1'b0;
    wait (scl_in === 1'b1);
    #16 r = sda_in;
    #16 scl_low_out = 1'b1;
    #16;
  endtask
  task automatic start();
    sda_low_out = 1'b1;
    #32 scl_low_out = 1'b1;
    #16;
  endtask
  task automatic xfer(input logic [7:0] d, input logic mn, output logic [7:0] q,
      output logic sn);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(mn, sn);
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    #16 scl_low_out = 1'b0;
    wait (scl_in === 1'b1);
    #32 sda_low_out = 1'b0;
    #64;
  endtask
endmodule

/* verification/its_target_bench.sv */
// self-checking bench for the i2c target
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module its_target_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import its_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [7:0] rx;
  logic ack;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  wire logic [31:0] hrdata;
  wire logic hready, scl_o, scl_oe, sda_o, sda_oe, irq, m_scl_low, m_sda_low;
  // both lines have pull-ups, so a released line reads high
  wire logic scl = !m_scl_low && (!scl_oe || scl_o);
  wire logic sda = !m_sda_low && (!sda_oe || sda_o);
  its_target dut_u (.CLK_SYS_IN(clk_sys), .NRST_IN(nrst), .HSEL_IN(1'b1), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(HSIZE_WORD), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(),
    .SCL_IN(scl), .SCL_OUT(scl_o), .SCL_OE_OUT(scl_oe), .SDA_IN(sda), .SDA_OUT(sda_o),
    .SDA_OE_OUT(sda_oe), .IRQ_OUT(irq));
  its_master_model mdl_u (.scl_in(scl), .sda_in(sda), .scl_low_out(m_scl_low),
    .sda_low_out(m_sda_low));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
    @(posedge clk_sys);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK("register", {24'h0, e}, rd)
  endtask
  task automatic t_regs();
    logic [7:0] ofs [6] = '{OFS_CONTROL, OFS_STATUS, OFS_MASK, OFS_OWN_ID, OFS_BUFFER, 8'h18};
    foreach (ofs[i]) rchk(ofs[i], 8'h00);
    bus(1'b1, 8'h18, 8'hFF);
    rchk(8'h18, 8'h00);
    bus(1'b1, OFS_MASK, 8'hFF);
    rchk(OFS_MASK, 8'hFF);
    bus(1'b1, OFS_BUFFER, 8'h5C);
    rchk(OFS_BUFFER, 8'h5C);
    bus(1'b1, OFS_CONTROL, 8'h1D);
    rchk(OFS_CONTROL, 8'h1D);
    bus(1'b1, OFS_OWN_ID, 8'hAA);
    rchk(OFS_OWN_ID, 8'h2A);
    bus(1'b1, OFS_CONTROL, 8'h01);
    bus(1'b1, OFS_MASK, 8'h00);
  endtask
  task automatic t_rx();
    mdl_u.start();
    mdl_u.xfer({7'h2A, 1'b0}, 1'b1, rx, ack);
    `CHK("addr ack", 1'b0, ack)
    `CHK("irq masked", 1'b0, irq)
    bus(1'b1, OFS_MASK, 8'h01);
    `CHK("irq", 1'b1, irq)
    bus(1'b0, OFS_STATUS, 8'h00);
    `CHK("status", 8'h09, rd[7:0] & 8'h09)
    `CHK("irq cleared", 1'b0, irq)
    bus(1'b0, OFS_STATUS, 8'h00);
    `CHK("sticky", 8'h00, rd[7:0] & 8'h11)
    bus(1'b1, OFS_GO, 8'h00);
    mdl_u.xfer(8'hA5, 1'b1, rx, ack);
    `CHK("data ack", 1'b0, ack)
    bus(1'b0, OFS_BUFFER, 8'h00);
    `CHK("rx byte", 8'hA5, rd[7:0])
    bus(1'b0, OFS_STATUS, 8'h00);
    `CHK("addr flag", 8'h01, rd[7:0] & 8'h09)
    bus(1'b1, OFS_CONTROL, 8'h05);
    mdl_u.xfer(8'h3C, 1'b1, rx, ack);
    `CHK("nack", 1'b1, ack)
    bus(1'b1, OFS_CONTROL, 8'h01);
    mdl_u.stop();
    bus(1'b0, OFS_STATUS, 8'h00);
    `CHK("stop", 8'h10, rd[7:0] & 8'h10)
  endtask
  task automatic t_addr();
    logic [7:0] ctl [3] = '{8'h01, 8'h11, 8'h00};
    logic [6:0] ad [3] = '{7'h15, 7'h15, 7'h2A};
    logic nak [3] = '{1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, OFS_CONTROL, ctl[i]);
      mdl_u.start();
      mdl_u.xfer({ad[i], 1'b0}, 1'b1, rx, ack);
      `CHK("match", nak[i], ack)
      bus(1'b1, OFS_CONTROL, ctl[i]);
      mdl_u.stop();
    end
  endtask
  task automatic t_tx();
    bus(1'b1, OFS_CONTROL, 8'h09);
    mdl_u.start();
    mdl_u.xfer({7'h2A, 1'b1}, 1'b1, rx, ack);
    `CHK("read ack", 1'b0, ack)
    bus(1'b1, OFS_BUFFER, 8'hC3);
    bus(1'b1, OFS_GO, 8'h00);
    mdl_u.xfer(8'hFF, 1'b1, rx, ack);
    `CHK("sent byte", 8'hC3, rx)
    bus(1'b0, OFS_STATUS, 8'h00);
    `CHK("last ack", 8'h03, rd[7:0] & 8'h03)
    bus(1'b1, OFS_CONTROL, 8'h01);
    mdl_u.stop();
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs();
    t_rx();
    t_addr();
    t_tx();
    results();
  end
endmodule

/* verification/its_target_props.sv */
// port assertions for the i2c target
module its_target_props
  import its_pkg::*;
(
  // watched ports
  input wire logic CLK_SYS_IN,
  input wire logic NRST_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic SCL_IN,
  input wire logic SCL_OE_OUT,
  input wire logic SDA_OE_OUT,
  input wire logic IRQ_OUT
);
  logic ph_ff;
  logic ph_w_ff;
  logic [7:0] ph_a_ff;
  logic [7:0] ctl_ff;
  logic [7:0] mask_ff;
  logic [7:0] id_ff;
  wire logic wp = ph_ff && ph_w_ff && HREADY_IN;
  wire logic rp = ph_ff && !ph_w_ff;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!NRST_IN);
  // shadow registers rebuilt from bus traffic only
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      ph_ff <= 1'b0;
      ctl_ff <= 8'h00;
      mask_ff <= 8'h00;
      id_ff <= 8'h00;
    end else begin
      if (wp && ph_a_ff == OFS_CONTROL) ctl_ff <= HWDATA_IN[7:0];
      if (wp && ph_a_ff == OFS_MASK) mask_ff <= HWDATA_IN[7:0];
      if (wp && ph_a_ff == OFS_OWN_ID) id_ff <= {1'b0, HWDATA_IN[6:0]};
      if (HREADY_IN) ph_ff <= HTRANS_IN[1];
      if (HREADY_IN) ph_w_ff <= HWRITE_IN;
      if (HREADY_IN) ph_a_ff <= HADDR_IN[7:0];
    end
  end
  property p_ctl;
    rp && ph_a_ff == OFS_CONTROL |-> HRDATA_OUT == {24'h0, ctl_ff};
  endproperty
  a_ctl: assert property (p_ctl) else $error("control read");
  property p_mask;
    rp && ph_a_ff == OFS_MASK |-> HRDATA_OUT == {24'h0, mask_ff};
  endproperty
  a_mask: assert property (p_mask) else $error("mask read");
  property p_id;
    rp && ph_a_ff == OFS_OWN_ID |-> HRDATA_OUT == {24'h0, id_ff};
  endproperty
  a_id: assert property (p_id) else $error("own id read");
  property p_st;
    rp && ph_a_ff == OFS_STATUS |-> (HRDATA_OUT & ~{24'h0, STATUS_USED}) == 32'h0;
  endproperty
  a_st: assert property (p_st) else $error("status spare bits");
  property p_off;
    !ctl_ff[CTL_ENABLE] [*2] |-> !SDA_OE_OUT && !SCL_OE_OUT;
  endproperty
  a_off: assert property (p_off) else $error("drives while off");
  property p_irq;
    mask_ff == 8'h00 |-> !IRQ_OUT;
  endproperty
  a_irq: assert property (p_irq) else $error("irq unmasked");
  property p_go;
    wp && ph_a_ff == OFS_GO |-> ##[1:4] !SCL_OE_OUT;
  endproperty
  a_go: assert property (p_go) else $error("go kept stretch");
  property p_sda;
    $rose(SDA_OE_OUT) |-> !SCL_IN;
  endproperty
  a_sda: assert property (p_sda) else $error("sda moved, scl high");
endmodule
bind its_target its_target_props props_u (.CLK_SYS_IN(CLK_SYS_IN), .NRST_IN(NRST_IN),
  .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN),
  .HWDATA_IN(HWDATA_IN), .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT),
  .SCL_IN(SCL_IN), .SCL_OE_OUT(SCL_OE_OUT), .SDA_OE_OUT(SDA_OE_OUT), .IRQ_OUT(IRQ_OUT));
